// ---- core/tpm_cfg.svh ----
`ifndef TPM_CFG_SVH
`define TPM_CFG_SVH

// Register addresses in the core's special-function space
`define TPM_ADDR_CTRL 8'h88
`define TPM_ADDR_MODE 8'h89

// Reset values
`define TPM_CTRL_RST 8'h00
`define TPM_MODE_RST 8'h00
`define TPM_CNT_RST 16'h0000
`define TPM_RDATA_RST 8'h00
`define TPM_PIN_IDLE 1'b1

// Control register fields
`define TPM_B_OVF 7
`define TPM_B_RUN 6
`define TPM_A_OVF 5
`define TPM_A_RUN 4
`define TPM_B_IRQ 3
`define TPM_B_TYPE 2
`define TPM_A_IRQ 1
`define TPM_A_TYPE 0

// Mode register fields
`define TPM_B_QUAL 7
`define TPM_B_SRC 6
`define TPM_B_MODE_HI 5
`define TPM_B_MODE_LO 4
`define TPM_A_QUAL 3
`define TPM_A_SRC 2
`define TPM_A_MODE_HI 1
`define TPM_A_MODE_LO 0

// Core clock dividers for the timer rates
`define TPM_DIV_FAST 4
`define TPM_DIV_SLOW 12

// Count byte write selects
`define TPM_SEL_A_LOW 2'h0
`define TPM_SEL_A_HIGH 2'h1
`define TPM_SEL_B_LOW 2'h2
`define TPM_SEL_B_HIGH 2'h3

`endif

// ---- core/tpm_pkg.sv ----
package tpm_pkg;

   // Counting modes, in mode field order
   typedef enum logic [1:0] {TPM_MODE_13, TPM_MODE_16, TPM_MODE_RELOAD, TPM_MODE_SPLIT} tpm_mode_t;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } tpm_sync_t;

   typedef struct packed {
      logic [1:0] cnt_fast;
      logic [3:0] cnt_slow;
      logic tick_fast;
      logic tick_slow;
   } tpm_div_t;

   typedef struct packed {
      logic ovf;
      logic [15:0] cnt;
   } tpm_step_t;

   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] mode;
      logic [15:0] cnt_a;
      logic [15:0] cnt_b;
      logic pulse_a;
      logic pulse_b;
      logic [7:0] rdata;
   } tpm_core_t;

endpackage : tpm_pkg

// ---- core/tpm_tick_if.sv ----
`timescale 1ns/1ps
// Divided core clock ticks, one clock wide each
interface tpm_tick_if;
   logic tick_fast;
   logic tick_slow;
   modport src (output tick_fast, output tick_slow);
   modport dst (input tick_fast, input tick_slow);
endinterface : tpm_tick_if

// ---- core/tpm_pin_sync.sv ----
`timescale 1ns/1ps
`include "tpm_cfg.svh"
module tpm_pin_sync
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pin,
   output logic level,
   output logic fall
);
   tpm_pkg::tpm_sync_t st_reg;
   tpm_pkg::tpm_sync_t st_next;

   // Two stages against metastability, third stage for the previous sample
   always_comb
   begin
      st_next.s1 = pin;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
   end

   // Idle high so release from reset gives no false edge
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st_reg <= '{s1: `TPM_PIN_IDLE, s2: `TPM_PIN_IDLE, s3: `TPM_PIN_IDLE};
      else
         st_reg <= st_next;
   end

   assign level = st_reg.s2;
   assign fall = st_reg.s3 & ~st_reg.s2;

   a_fall_two_samples:
   assert property (@(posedge clk) disable iff (!rst_n)
      fall |-> (!level && $past(level)))
   else $error("fall seen without high then low sample");

endmodule : tpm_pin_sync

// ---- core/tpm_prescale.sv ----
`timescale 1ns/1ps
`include "tpm_cfg.svh"
module tpm_prescale
(
   input wire logic clk,
   input wire logic rst_n,
   tpm_tick_if.src ticks
);
   localparam logic [1:0] FAST_LAST = 2'(`TPM_DIV_FAST - 1);
   localparam logic [3:0] SLOW_LAST = 4'(`TPM_DIV_SLOW - 1);

   tpm_pkg::tpm_div_t st_reg;
   tpm_pkg::tpm_div_t st_next;

   // Free-running dividers; ticks are one clock wide
   always_comb
   begin
      st_next = st_reg;
      st_next.tick_fast = (st_reg.cnt_fast == FAST_LAST);
      st_next.tick_slow = (st_reg.cnt_slow == SLOW_LAST);
      st_next.cnt_fast = st_next.tick_fast ? 2'h0 : st_reg.cnt_fast + 2'h1;
      st_next.cnt_slow = st_next.tick_slow ? 4'h0 : st_reg.cnt_slow + 4'h1;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st_reg <= '{cnt_fast: 2'h0, cnt_slow: 4'h0, tick_fast: 1'b0, tick_slow: 1'b0};
      else
         st_reg <= st_next;
   end

   assign ticks.tick_fast = st_reg.tick_fast;
   assign ticks.tick_slow = st_reg.tick_slow;

   a_slow_tick_spacing:
   assert property (@(posedge clk) disable iff (!rst_n)
      st_reg.tick_slow |=> !st_reg.tick_slow [*8] ##1 !st_reg.tick_slow ##1 !st_reg.tick_slow
         ##1 !st_reg.tick_slow ##1 st_reg.tick_slow)
   else $error("slow tick not every twelve clocks");

endmodule : tpm_prescale

// ---- core/tpm_timer_pair.sv ----
`timescale 1ns/1ps
// Function
// - Timer B with qualify set counts only when run is set and pin B high.
// - Timer A, split high byte aside, with qualify set counts only when run is set and pin A high.
// - Timer B counts core clock over 4 or 12, or its count pin.
// - Timer A counts core clock over 4 or 12, or its count pin.
// - Timer B modes: 13-bit, 16-bit, 8-bit reload, or stopped holding value.
// - Timer A modes: 13-bit, 16-bit, 8-bit reload, or two 8-bit counters.
// - Timer B overflow sets its flag unless timer A is split; vectoring to the routine clears it.
// - Timer B counts only while software keeps its run bit set.
// - Timer A overflow sets its flag; vectoring to the routine clears it.
// - Timer A, split high byte aside, counts only while software keeps its run bit set.
// - Edge mode: pin B falling edge sets request B; vectoring or software clears.
// - Level mode: request B follows inverse of pin B; software writes ignored.
// - Type bit B: 1 selects falling edge, 0 selects low level.
// - Edge mode: pin A falling edge sets request A; vectoring or software clears.
// - Level mode: request A follows inverse of pin A; software writes ignored.
// - Type bit A: 1 selects falling edge, 0 selects low level.
// - 13-bit mode wraps from all ones, sets flag, pulses overflow one clock.
// - 16-bit mode wraps from all ones, same flag and pulse behaviour.
// - Reload mode: low byte counts, reloads from high byte after all ones.
// - Timer A split: high byte counts divided clock using timer B run and flag.
`include "tpm_cfg.svh"
module tpm_timer_pair
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_rd,
   output logic [7:0] sfr_rdata,
   input wire logic timer_a_rate_select,
   input wire logic timer_b_rate_select,
   input wire logic cnt_wr,
   input wire logic [1:0] cnt_sel,
   input wire logic [7:0] cnt_wdata,
   input wire logic vec_ack_timer_a,
   input wire logic vec_ack_timer_b,
   input wire logic vec_ack_irq_a,
   input wire logic vec_ack_irq_b,
   input wire logic irq_pin_a_n,
   input wire logic irq_pin_b_n,
   input wire logic count_pin_a,
   input wire logic count_pin_b,
   output logic overflow_pulse_a,
   output logic overflow_pulse_b,
   output logic [15:0] timer_a_count,
   output logic [15:0] timer_b_count,
   output logic [7:0] timer_control_value
);
   localparam tpm_pkg::tpm_core_t CORE_RST = '{
      ctrl: `TPM_CTRL_RST, mode: `TPM_MODE_RST, cnt_a: `TPM_CNT_RST, cnt_b: `TPM_CNT_RST,
      pulse_a: 1'b0, pulse_b: 1'b0, rdata: `TPM_RDATA_RST};

   tpm_pkg::tpm_core_t st_reg;
   tpm_pkg::tpm_core_t st_next;

   logic irq_a_lvl;
   logic irq_a_fall;
   logic irq_b_lvl;
   logic irq_b_fall;
   logic cnt_a_lvl;
   logic cnt_a_fall;
   logic cnt_b_lvl;
   logic cnt_b_fall;

   tpm_tick_if tick_bus ();

   tpm_prescale u_prescale
   (
      .clk(clk),
      .rst_n(rst_n),
      .ticks(tick_bus)
   );

   // All four pins pass the same synchroniser before any use
   tpm_pin_sync u_sync_irq_a
   (
      .clk(clk),
      .rst_n(rst_n),
      .pin(irq_pin_a_n),
      .level(irq_a_lvl),
      .fall(irq_a_fall)
   );

   tpm_pin_sync u_sync_irq_b
   (
      .clk(clk),
      .rst_n(rst_n),
      .pin(irq_pin_b_n),
      .level(irq_b_lvl),
      .fall(irq_b_fall)
   );

   tpm_pin_sync u_sync_cnt_a
   (
      .clk(clk),
      .rst_n(rst_n),
      .pin(count_pin_a),
      .level(cnt_a_lvl),
      .fall(cnt_a_fall)
   );

   tpm_pin_sync u_sync_cnt_b
   (
      .clk(clk),
      .rst_n(rst_n),
      .pin(count_pin_b),
      .level(cnt_b_lvl),
      .fall(cnt_b_fall)
   );

   // One count step in a given mode; split mode only moves the low byte
   function automatic tpm_pkg::tpm_step_t step_cnt
   (
      input tpm_pkg::tpm_mode_t m,
      input logic [15:0] c
   );
      tpm_pkg::tpm_step_t r;
      logic [12:0] v13;
      r.ovf = 1'b0;
      r.cnt = c;
      v13 = {c[15:8], c[4:0]} + 13'h1;
      case (m)
         tpm_pkg::TPM_MODE_13:
         begin
            r.ovf = (c[15:8] == 8'hff) && (c[4:0] == 5'h1f);
            r.cnt = {v13[12:5], c[7:5], v13[4:0]};
         end
         tpm_pkg::TPM_MODE_16:
         begin
            r.ovf = (c == 16'hffff);
            r.cnt = c + 16'h1;
         end
         tpm_pkg::TPM_MODE_RELOAD:
         begin
            r.ovf = (c[7:0] == 8'hff);
            r.cnt[7:0] = r.ovf ? c[15:8] : c[7:0] + 8'h1;
         end
         default:
         begin
            r.ovf = (c[7:0] == 8'hff);
            r.cnt[7:0] = c[7:0] + 8'h1;
         end
      endcase
      return r;
   endfunction : step_cnt

   tpm_pkg::tpm_mode_t mode_a;
   tpm_pkg::tpm_mode_t mode_b;
   logic split_a;
   logic tick_a;
   logic tick_b;
   logic tick_ah;
   logic en_a;
   logic en_b;
   logic en_ah;
   logic ovf_a;
   logic ovf_b;
   logic ovf_ah;
   tpm_pkg::tpm_step_t step_a;
   tpm_pkg::tpm_step_t step_b;

   // Count sources, gating and mode decode
   always_comb
   begin
      mode_a = tpm_pkg::tpm_mode_t'(st_reg.mode[`TPM_A_MODE_HI:`TPM_A_MODE_LO]);
      mode_b = tpm_pkg::tpm_mode_t'(st_reg.mode[`TPM_B_MODE_HI:`TPM_B_MODE_LO]);
      split_a = (mode_a == tpm_pkg::TPM_MODE_SPLIT);
      tick_a = st_reg.mode[`TPM_A_SRC] ? cnt_a_fall
         : (timer_a_rate_select ? tick_bus.tick_fast : tick_bus.tick_slow);
      tick_b = st_reg.mode[`TPM_B_SRC] ? cnt_b_fall
         : (timer_b_rate_select ? tick_bus.tick_fast : tick_bus.tick_slow);
      // High byte of a split timer A never sees the count pin
      tick_ah = timer_a_rate_select ? tick_bus.tick_fast : tick_bus.tick_slow;
      en_a = st_reg.ctrl[`TPM_A_RUN]
         && (!st_reg.mode[`TPM_A_QUAL] || irq_a_lvl) && tick_a;
      en_b = st_reg.ctrl[`TPM_B_RUN]
         && (!st_reg.mode[`TPM_B_QUAL] || irq_b_lvl) && tick_b
         && (mode_b != tpm_pkg::TPM_MODE_SPLIT);
      en_ah = split_a && st_reg.ctrl[`TPM_B_RUN] && tick_ah;
      step_a = step_cnt(mode_a, st_reg.cnt_a);
      step_b = step_cnt(mode_b, st_reg.cnt_b);
      ovf_a = en_a && step_a.ovf;
      ovf_b = en_b && step_b.ovf;
      ovf_ah = en_ah && (st_reg.cnt_a[15:8] == 8'hff);
   end

   // Next state: counters, then software writes, then hardware flag events
   always_comb
   begin
      st_next = st_reg;
      st_next.pulse_a = ovf_a;
      st_next.pulse_b = ovf_b || ovf_ah;
      if (en_a)
         st_next.cnt_a = step_a.cnt;
      if (en_ah)
         st_next.cnt_a[15:8] = st_reg.cnt_a[15:8] + 8'h1;
      if (en_b)
         st_next.cnt_b = step_b.cnt;
      // A byte write overrides a count step in the same clock
      if (cnt_wr)
      begin
         case (cnt_sel)
            `TPM_SEL_A_LOW: st_next.cnt_a[7:0] = cnt_wdata;
            `TPM_SEL_A_HIGH: st_next.cnt_a[15:8] = cnt_wdata;
            `TPM_SEL_B_LOW: st_next.cnt_b[7:0] = cnt_wdata;
            default: st_next.cnt_b[15:8] = cnt_wdata;
         endcase
      end
      if (sfr_wr && sfr_addr == `TPM_ADDR_MODE)
         st_next.mode = sfr_wdata;
      if (sfr_wr && sfr_addr == `TPM_ADDR_CTRL)
      begin
         st_next.ctrl[`TPM_B_OVF] = sfr_wdata[`TPM_B_OVF];
         st_next.ctrl[`TPM_B_RUN] = sfr_wdata[`TPM_B_RUN];
         st_next.ctrl[`TPM_A_OVF] = sfr_wdata[`TPM_A_OVF];
         st_next.ctrl[`TPM_A_RUN] = sfr_wdata[`TPM_A_RUN];
         st_next.ctrl[`TPM_B_TYPE] = sfr_wdata[`TPM_B_TYPE];
         st_next.ctrl[`TPM_A_TYPE] = sfr_wdata[`TPM_A_TYPE];
         st_next.ctrl[`TPM_B_IRQ] = sfr_wdata[`TPM_B_IRQ];
         st_next.ctrl[`TPM_A_IRQ] = sfr_wdata[`TPM_A_IRQ];
      end
      // Vector clears first so that a same-clock overflow still lands
      if (vec_ack_timer_a)
         st_next.ctrl[`TPM_A_OVF] = 1'b0;
      if (vec_ack_timer_b)
         st_next.ctrl[`TPM_B_OVF] = 1'b0;
      if (ovf_a)
         st_next.ctrl[`TPM_A_OVF] = 1'b1;
      // In split mode the high byte of A owns timer B's flag
      if (split_a ? ovf_ah : ovf_b)
         st_next.ctrl[`TPM_B_OVF] = 1'b1;
      if (st_reg.ctrl[`TPM_A_TYPE])
      begin
         if (vec_ack_irq_a)
            st_next.ctrl[`TPM_A_IRQ] = 1'b0;
         if (irq_a_fall)
            st_next.ctrl[`TPM_A_IRQ] = 1'b1;
      end
      else
         st_next.ctrl[`TPM_A_IRQ] = !irq_a_lvl;
      if (st_reg.ctrl[`TPM_B_TYPE])
      begin
         if (vec_ack_irq_b)
            st_next.ctrl[`TPM_B_IRQ] = 1'b0;
         if (irq_b_fall)
            st_next.ctrl[`TPM_B_IRQ] = 1'b1;
      end
      else
         st_next.ctrl[`TPM_B_IRQ] = !irq_b_lvl;
      // Read data registered; unmapped addresses read zero
      if (sfr_rd)
      begin
         case (sfr_addr)
            `TPM_ADDR_CTRL: st_next.rdata = st_reg.ctrl;
            `TPM_ADDR_MODE: st_next.rdata = st_reg.mode;
            default: st_next.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st_reg <= CORE_RST;
      else
         st_reg <= st_next;
   end

   // Every output straight from the state register
   assign sfr_rdata = st_reg.rdata;
   assign overflow_pulse_a = st_reg.pulse_a;
   assign overflow_pulse_b = st_reg.pulse_b;
   assign timer_a_count = st_reg.cnt_a;
   assign timer_b_count = st_reg.cnt_b;
   assign timer_control_value = st_reg.ctrl;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   a_flag_a_set:
   assert property (st_reg.pulse_a |-> st_reg.ctrl[`TPM_A_OVF])
   else $error("timer A pulse without overflow flag");

   a_flag_b_set:
   assert property ((st_reg.pulse_b && $past(mode_a) != tpm_pkg::TPM_MODE_SPLIT)
      |-> st_reg.ctrl[`TPM_B_OVF])
   else $error("timer B pulse without overflow flag");

   a_run_b_hold:
   assert property ((!st_reg.ctrl[`TPM_B_RUN] && !cnt_wr) |=> $stable(st_reg.cnt_b))
   else $error("timer B moved with run clear");

   a_run_a_hold:
   assert property ((!st_reg.ctrl[`TPM_A_RUN] && !split_a && !cnt_wr) |=> $stable(st_reg.cnt_a))
   else $error("timer A moved with run clear");

   a_stop_b_hold:
   assert property ((mode_b == tpm_pkg::TPM_MODE_SPLIT && !cnt_wr) |=> $stable(st_reg.cnt_b))
   else $error("timer B moved while stopped");

   a_gate_b_low:
   assert property ((st_reg.mode[`TPM_B_QUAL] && !irq_b_lvl) |-> !en_b)
   else $error("timer B counted with gate pin low");

   a_level_a_track:
   assert property (!st_reg.ctrl[`TPM_A_TYPE] |=> st_reg.ctrl[`TPM_A_IRQ] == !$past(irq_a_lvl))
   else $error("level request A not following pin");

   a_level_b_track:
   assert property (!st_reg.ctrl[`TPM_B_TYPE] |=> st_reg.ctrl[`TPM_B_IRQ] == !$past(irq_b_lvl))
   else $error("level request B not following pin");

   a_edge_b_set:
   assert property ((st_reg.ctrl[`TPM_B_TYPE] && irq_b_fall) |=> st_reg.ctrl[`TPM_B_IRQ])
   else $error("edge request B lost");

   a_edge_a_set:
   assert property ((st_reg.ctrl[`TPM_A_TYPE] && irq_a_fall) |=> st_reg.ctrl[`TPM_A_IRQ])
   else $error("edge request A lost");

   a_wrap_16_zero:
   assert property ((ovf_a && mode_a == tpm_pkg::TPM_MODE_16 && !cnt_wr)
      |=> st_reg.cnt_a == 16'h0000 ##1 !st_reg.pulse_a)
   else $error("16-bit wrap wrong or pulse too long");

   a_reload_low:
   assert property ((ovf_b && mode_b == tpm_pkg::TPM_MODE_RELOAD && !cnt_wr)
      |=> st_reg.cnt_b[7:0] == $past(st_reg.cnt_b[15:8]))
   else $error("reload value not taken");

   // Vector clears must land unless an overflow or fall comes in the same clock
   a_vec_a_clear:
   assert property ((vec_ack_timer_a && !ovf_a) |=> !st_reg.ctrl[`TPM_A_OVF])
   else $error("timer A flag not cleared by vector");

   a_vec_b_clear:
   assert property ((vec_ack_timer_b && !(split_a ? ovf_ah : ovf_b))
      |=> !st_reg.ctrl[`TPM_B_OVF])
   else $error("timer B flag not cleared by vector");

   a_edge_a_clear:
   assert property ((st_reg.ctrl[`TPM_A_TYPE] && vec_ack_irq_a && !irq_a_fall)
      |=> !st_reg.ctrl[`TPM_A_IRQ])
   else $error("edge request A not cleared by vector");

   a_edge_b_clear:
   assert property ((st_reg.ctrl[`TPM_B_TYPE] && vec_ack_irq_b && !irq_b_fall)
      |=> !st_reg.ctrl[`TPM_B_IRQ])
   else $error("edge request B not cleared by vector");

endmodule : tpm_timer_pair

// ---- verif/tpm_pin_model.sv ----
`timescale 1ns/1ps
// Far-side count pin: idle high through its pull-up, emits bursts of falls
module tpm_pin_model
(
   input wire logic clk,
   input wire logic go,
   input wire logic [3:0] num,
   input wire logic [3:0] gap,
   output logic count_pin,
   output logic busy
);
   initial
   begin
      count_pin = 1'b1;
      busy = 1'b0;
   end

   // Each low and high phase lasts gap clocks, so a large gap acts as a slow source
   always
   begin
      @(posedge clk);
      if (go)
      begin
         busy <= 1'b1;
         for (int i = 0; i < num; i++)
         begin
            count_pin <= 1'b0;
            repeat (gap) @(posedge clk);
            count_pin <= 1'b1;
            repeat (gap) @(posedge clk);
         end
         busy <= 1'b0;
      end
   end
endmodule : tpm_pin_model

// ---- verif/timer_pair_mode_and_control_bench.sv ----
`timescale 1ns/1ps
`include "tpm_cfg.svh"
module timer_pair_mode_and_control_bench;
   logic clk = 1'b0, rst_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, cnt_wr = 1'b0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, cnt_wdata = 8'h00, sfr_rdata, ctl, v;
   logic [1:0] cnt_sel = 2'h0;
   logic ra = 1'b1, rb = 1'b1, pa = 1'b1, pb = 1'b1, go = 1'b0, busy, cpin_b;
   logic [3:0] vk = 4'h0, num = 4'h0, gap = 4'h0;
   logic pulse_a, pulse_b;
   logic [15:0] cnt_a, cnt_b, da, db;
   int err_total = 0;
   int checks = 0;

   always #50 clk = ~clk;

   tpm_timer_pair tpm_timer_pair_inst (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
      .timer_a_rate_select(ra), .timer_b_rate_select(rb), .cnt_wr(cnt_wr),
      .cnt_sel(cnt_sel), .cnt_wdata(cnt_wdata), .vec_ack_timer_a(vk[0]),
      .vec_ack_timer_b(vk[1]), .vec_ack_irq_a(vk[2]), .vec_ack_irq_b(vk[3]),
      .irq_pin_a_n(pa), .irq_pin_b_n(pb), .count_pin_a(cpin_b), .count_pin_b(cpin_b),
      .overflow_pulse_a(pulse_a), .overflow_pulse_b(pulse_b), .timer_a_count(cnt_a),
      .timer_b_count(cnt_b), .timer_control_value(ctl));

   tpm_pin_model tpm_pin_model_inst (.clk(clk), .go(go), .num(num), .gap(gap),
      .count_pin(cpin_b), .busy(busy));

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish

   // Bus tasks start on a rising edge and release at the edge that takes them
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge clk);
      sfr_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge clk);
      sfr_rd <= 1'b0;
      @(negedge clk);
      d = sfr_rdata;
   endtask : rd

   task automatic cw(input logic [1:0] s, input logic [7:0] d);
      @(posedge clk);
      cnt_sel <= s;
      cnt_wdata <= d;
      cnt_wr <= 1'b1;
      @(posedge clk);
      cnt_wr <= 1'b0;
   endtask : cw

   task automatic vack(input logic [3:0] m);
      @(posedge clk);
      vk <= m;
      @(posedge clk);
      vk <= 4'h0;
      @(negedge clk);
   endtask : vack

   task automatic pins(input logic a, input logic b);
      @(posedge clk);
      pa <= a;
      pb <= b;
      repeat (5) @(negedge clk);
   endtask : pins

   // Bounded wait for an overflow pulse; a hang ends the run
   task automatic wait_pulse(input bit b);
      int n;
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
      end
      while (((b ? pulse_b : pulse_a) !== 1'b1) && n < 2000);
      if (n >= 2000)
      begin
         err_total++;
         tally_and_finish();
      end
   endtask : wait_pulse

   // Count deltas over a window; tick phase cancels out over whole periods
   task automatic meas(input int n, output logic [15:0] a, output logic [15:0] b);
      logic [15:0] a0, b0;
      @(negedge clk);
      a0 = cnt_a;
      b0 = cnt_b;
      repeat (n) @(negedge clk);
      a = cnt_a - a0;
      b = cnt_b - b0;
   endtask : meas

   task automatic burst(input logic [3:0] k, input logic [3:0] g, input logic [15:0] exp,
      input logic [15:0] exp_a);
      logic [15:0] b0, a0;
      int n;
      @(negedge clk);
      b0 = cnt_b;
      a0 = cnt_a;
      @(posedge clk);
      num <= k;
      gap <= g;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
      end
      while (busy === 1'b1 && n < 500);
      if (n >= 500)
      begin
         err_total++;
         tally_and_finish();
      end
      repeat (6) @(negedge clk);
      chk("count pin delta", cnt_b - b0, exp);
      chk("count pin a delta", cnt_a - a0, exp_a);
   endtask : burst

   initial
   begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      // Reset state, unmapped place, plain register access
      rd(`TPM_ADDR_CTRL, v);
      chk("ctrl reset", 16'(v), 16'h0000);
      rd(`TPM_ADDR_MODE, v);
      chk("mode reset", 16'(v), 16'h0000);
      chk("count a reset", cnt_a, 16'h0000);
      wr(8'h8a, 8'h77);
      rd(8'h8a, v);
      chk("unmapped read", 16'(v), 16'h0000);
      wr(`TPM_ADDR_MODE, 8'h5a);
      rd(`TPM_ADDR_MODE, v);
      chk("mode readback", 16'(v), 16'h005a);
      // Timer A 16-bit wrap, flag, one-clock pulse, vector clear
      wr(`TPM_ADDR_MODE, 8'h01);
      cw(`TPM_SEL_A_HIGH, 8'hff);
      cw(`TPM_SEL_A_LOW, 8'hfe);
      wr(`TPM_ADDR_CTRL, 8'h10);
      wait_pulse(1'b0);
      chk("a wrap 16", cnt_a, 16'h0000);
      chk("a flag", 16'(ctl[5]), 16'h0001);
      @(negedge clk);
      chk("a pulse width", 16'(pulse_a), 16'h0000);
      vack(4'h1);
      chk("a flag vector", 16'(ctl[5]), 16'h0000);
      // Timer A 13-bit wrap; top low bits keep their value
      wr(`TPM_ADDR_CTRL, 8'h00);
      wr(`TPM_ADDR_MODE, 8'h00);
      cw(`TPM_SEL_A_HIGH, 8'hff);
      cw(`TPM_SEL_A_LOW, 8'hff);
      wr(`TPM_ADDR_CTRL, 8'h10);
      wait_pulse(1'b0);
      chk("a wrap 13", cnt_a, 16'h00e0);
      chk("a flag 13", 16'(ctl[5]), 16'h0001);
      // Timer B auto-reload
      wr(`TPM_ADDR_CTRL, 8'h00);
      wr(`TPM_ADDR_MODE, 8'h20);
      cw(`TPM_SEL_B_HIGH, 8'h80);
      cw(`TPM_SEL_B_LOW, 8'hff);
      wr(`TPM_ADDR_CTRL, 8'h40);
      wait_pulse(1'b1);
      chk("b reload", cnt_b, 16'h8080);
      chk("b flag", 16'(ctl[7]), 16'h0001);
      vack(4'h2);
      chk("b flag vector", 16'(ctl[7]), 16'h0000);
      // Split A with B stopped: A high borrows B run and flag
      wr(`TPM_ADDR_CTRL, 8'h00);
      wr(`TPM_ADDR_MODE, 8'h33);
      cw(`TPM_SEL_A_HIGH, 8'hff);
      cw(`TPM_SEL_A_LOW, 8'h12);
      cw(`TPM_SEL_B_HIGH, 8'h12);
      cw(`TPM_SEL_B_LOW, 8'h34);
      wr(`TPM_ADDR_CTRL, 8'h40);
      wait_pulse(1'b1);
      chk("split a", cnt_a, 16'h0012);
      chk("b held", cnt_b, 16'h1234);
      chk("split flag", 16'(ctl[7:5]), 16'h0006);
      // Rates: per 120 clocks, 30 fast ticks and 10 slow ones
      wr(`TPM_ADDR_CTRL, 8'h00);
      wr(`TPM_ADDR_MODE, 8'h11);
      wr(`TPM_ADDR_CTRL, 8'h50);
      @(posedge clk);
      rb <= 1'b0;
      meas(120, da, db);
      chk("a fast", da, 16'd30);
      chk("b slow", db, 16'd10);
      @(posedge clk);
      ra <= 1'b0;
      rb <= 1'b1;
      meas(120, da, db);
      chk("a slow", da, 16'd10);
      chk("b fast", db, 16'd30);
      wr(`TPM_ADDR_CTRL, 8'h00);
      meas(40, da, db);
      chk("stopped", da | db, 16'h0000);
      // Timer A qualified by pin A
      @(posedge clk);
      ra <= 1'b1;
      wr(`TPM_ADDR_MODE, 8'h09);
      wr(`TPM_ADDR_CTRL, 8'h10);
      pins(1'b0, 1'b1);
      meas(40, da, db);
      chk("a gated off", da, 16'd0);
      pins(1'b1, 1'b1);
      meas(40, da, db);
      chk("a gated on", da, 16'd10);
      // Timer B from its count pin, prompt and slow, then qualified
      wr(`TPM_ADDR_MODE, 8'h50);
      wr(`TPM_ADDR_CTRL, 8'h40);
      burst(4'h3, 4'h3, 16'd3, 16'd0);
      burst(4'h2, 4'h9, 16'd2, 16'd0);
      wr(`TPM_ADDR_MODE, 8'hd0);
      pins(1'b1, 1'b0);
      burst(4'h3, 4'h3, 16'd0, 16'd0);
      pins(1'b1, 1'b1);
      burst(4'h3, 4'h3, 16'd3, 16'd0);
      // Both timers on the shared count pin
      wr(`TPM_ADDR_MODE, 8'h55);
      wr(`TPM_ADDR_CTRL, 8'h50);
      burst(4'h2, 4'h3, 16'd2, 16'd2);
      // Level mode: flags follow the pins, writes ignored
      wr(`TPM_ADDR_CTRL, 8'h00);
      pins(1'b0, 1'b0);
      chk("level low", 16'(ctl[3:0]), 16'h000a);
      wr(`TPM_ADDR_CTRL, 8'h00);
      @(negedge clk);
      chk("level write", 16'(ctl[3:0]), 16'h000a);
      pins(1'b1, 1'b1);
      chk("level high", 16'(ctl[3:0]), 16'h0000);
      // Edge mode: latched on fall, cleared by software and by vector
      wr(`TPM_ADDR_CTRL, 8'h05);
      pins(1'b0, 1'b0);
      pins(1'b1, 1'b1);
      chk("edge latched", 16'(ctl[3:0]), 16'h000f);
      wr(`TPM_ADDR_CTRL, 8'h05);
      @(negedge clk);
      chk("edge sw clear", 16'(ctl[3:0]), 16'h0005);
      pins(1'b0, 1'b0);
      vack(4'hc);
      chk("edge vector", 16'(ctl[3:0]), 16'h0005);
      pins(1'b1, 1'b1);
      tally_and_finish();
   end
endmodule : timer_pair_mode_and_control_bench
